// ---- logic/aret_pkg.sv ----
// Constants for the retry-transmit and auto-acknowledge sequencer
package aret_pkg;
  // Clock and symbol timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int ACK_STD_US = 192;
  localparam int ACK_SHORT_US = 32;
  localparam int ACK_TMO_US = 864;
  localparam int ACK_STD_CYC = ACK_STD_US * 1000 / CLK_PERIOD_NS;
  localparam int ACK_SHORT_CYC = ACK_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int ACK_TMO_CYC = ACK_TMO_US * 1000 / CLK_PERIOD_NS;
  localparam int TMR_W = 18;
  // Register offsets
  localparam logic [5:0] REG_STATE_READBACK = 6'h01;
  localparam logic [5:0] REG_STATE_CONTROL = 6'h02;
  localparam logic [5:0] REG_RADIO_CTRL_B = 6'h04;
  localparam logic [5:0] REG_IRQ_MASK = 6'h0e;
  localparam logic [5:0] REG_IRQ_STATUS = 6'h0f;
  localparam logic [5:0] REG_EXT_CTRL_B = 6'h17;
  localparam logic [5:0] REG_EXT_CTRL_C = 6'h19;
  localparam logic [5:0] REG_EXT_CTRL_A = 6'h2c;
  // Field positions
  localparam int CMD_LSB = 0;
  localparam int RESULT_LSB = 5;
  localparam int ROUTE_EN_BIT = 6;
  localparam int ACK_DELAY_BIT = 2;
  localparam int TS_EN_BIT = 3;
  localparam int BCNT_LSB = 1;
  localparam int FCNT_LSB = 4;
  localparam int IRQ_PLL_BIT = 0;
  localparam int IRQ_RXSTART_BIT = 2;
  localparam int IRQ_DONE_BIT = 3;
  localparam int IRQ_AMI_BIT = 5;
  // Reset values
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] EXT_A_RST = 8'h38;
  // Commands written to the state command field
  localparam logic [4:0] CMD_TX_START = 5'h02;
  localparam logic [4:0] CMD_OFF = 5'h08;
  localparam logic [4:0] CMD_PLL_ON = 5'h09;
  localparam logic [4:0] CMD_AUTOACK_ON = 5'h16;
  localparam logic [4:0] CMD_RETRY_ON = 5'h19;
  // State readback codes
  localparam logic [4:0] ST_OFF = 5'h08;
  localparam logic [4:0] ST_PLL = 5'h09;
  localparam logic [4:0] ST_BUSY_AA = 5'h11;
  localparam logic [4:0] ST_BUSY_RT = 5'h12;
  localparam logic [4:0] ST_LISTEN = 5'h16;
  localparam logic [4:0] ST_RETRY_IDLE = 5'h19;
  // Transaction result codes, no-CSMA backoff limit and acknowledge-request bit
  localparam logic [2:0] RES_SUCCESS = 3'h0;
  localparam logic [2:0] RES_PENDING = 3'h1;
  localparam logic [2:0] RES_CHAN_BUSY = 3'h3;
  localparam logic [2:0] RES_NO_ACK = 3'h5;
  localparam logic [2:0] RES_INVALID = 3'h7;
  localparam logic [2:0] BACKOFF_NO_CSMA = 3'h7;
  localparam int FCF_ACK_REQ_BIT = 5;

  typedef enum logic [9:0] {
    S_OFF = 10'h001,
    S_PLL = 10'h002,
    S_LISTEN = 10'h004,
    S_BUSY_RX = 10'h008,
    S_ACK_DLY = 10'h010,
    S_ACK_TX = 10'h020,
    S_RETRY_IDLE = 10'h040,
    S_CSMA = 10'h080,
    S_TX = 10'h100,
    S_ACK_WAIT = 10'h200
  } aret_state_t;
endpackage : aret_pkg

// ---- logic/aret_pin_sync.sv ----
// Three-stage pin synchroniser with rising-edge pulse
module aret_pin_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Pin and edge
  input wire logic pin,
  output logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic stable_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level accepted only once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stable_q <= 1'b0;
      rise <= 1'b0;
    end else begin
      rise <= 1'b0;
      if (s2_q == s3_q) begin
        stable_q <= s2_q;
        rise <= s2_q & ~stable_q;
      end
    end
  end
endmodule : aret_pin_sync

// ---- logic/aret_engine.sv ----
// Retry-transmit and auto-acknowledge sequencer with register port
//
// Contract
// - Listening, a start-of-frame delimiter moves to busy-receiving auto-ack state.
// - Delay select clear: acknowledgment sent 12 symbols (192us) after frame.
// - Delay select set: acknowledgment sent two symbols after frame.
// - Transmit start runs CSMA-CA first; frame sent only on idle channel.
// - Transaction starts on trigger pin rising edge or transmit-go command.
// - Channel busy after backoff limit: abort, completion interrupt, result 3.
// - Acknowledge-request bit 5 of frame octet 1 decides acknowledgment wait.
// - Expecting acknowledgment: receive, then result from frame-pending subfield.
// - Frame buffer untouched during retry; other received frames discarded.
// - No acknowledgment within 54 symbols: retry whole transaction until limit exceeded.
// - Frame and backoff retry counts readable in register 0x19.
// - Transmit timestamping only when both route and timestamp enables set.
// - Result codes: 0 success, 1 pending, 3 busy, 5 no-ack, 7 unfinished.
// - No acknowledgment requested: completion interrupt after transmit, result success.
// - Backoff limit 7: no CSMA-CA, single attempt, frame limit ignored.
// - Busy-retry-transmit shown whole transaction, then retry-idle state.
// - Received acknowledgment pending bit selects pending-success or plain success.
// - Completion interrupt ends every retry transaction regardless of outcome.
// - Interrupts raised only when enabled in mask register 0x0E.
// - Auto-ack: header and match interrupts; completion only for filtered valid frames.
// - Entering either extended mode from off raises synthesizer-lock interrupt.
// - Result loaded with 7 at start of every transaction; resets to zero.
// - Acknowledgments in retry mode raise neither match nor completion interrupt; this design raises completion when one ends the wait.
//
// The register offsets and the strobed register port are this design's own decisions.
module aret_engine #(
  parameter int ACK_STD_CYCLES = aret_pkg::ACK_STD_CYC,
  parameter int ACK_SHORT_CYCLES = aret_pkg::ACK_SHORT_CYC,
  parameter int ACK_TMO_CYCLES = aret_pkg::ACK_TMO_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Host pins
  input wire logic sleep_tx_trigger_pin,
  output logic irq_pin,
  output logic timestamp_pin,
  // Radio front end, same clock
  output logic cca_start,
  input wire logic cca_done,
  input wire logic cca_idle,
  output logic tx_start,
  output logic tx_is_ack,
  input wire logic tx_done,
  input wire logic fb_octet1_bit,
  input wire logic rx_sfd,
  input wire logic rx_phr_ok,
  input wire logic rx_addr_match,
  input wire logic rx_end,
  input wire logic rx_fcs_ok,
  input wire logic rx_is_ack,
  input wire logic rx_ack_req,
  input wire logic rx_frame_pending,
  output logic fb_rx_write_en
);
  import aret_pkg::*;

  aret_state_t state_q;
  logic [2:0] result_q;
  logic [7:0] irq_mask_q;
  logic [7:0] irq_stat_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] ext_a_q;
  logic [7:0] ext_b_q;
  logic [2:0] bcnt_q;
  logic [3:0] fcnt_q;
  logic [TMR_W-1:0] tmr_q;
  logic amatch_q;
  logic pin_rise;
  logic cmd_wr;
  logic [4:0] cmd;
  logic start_evt;
  logic [2:0] backoff_limit;
  logic [3:0] frame_limit;
  logic [7:0] irq_set;
  logic [7:0] rdata_d;
  logic ack_ok;

  function automatic logic [4:0] state_code(input aret_state_t s);
    case (s)
      S_OFF: state_code = ST_OFF;
      S_PLL: state_code = ST_PLL;
      S_LISTEN: state_code = ST_LISTEN;
      S_BUSY_RX, S_ACK_DLY, S_ACK_TX: state_code = ST_BUSY_AA;
      S_RETRY_IDLE: state_code = ST_RETRY_IDLE;
      default: state_code = ST_BUSY_RT;
    endcase
  endfunction : state_code

  aret_pin_sync u_trig_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin(sleep_tx_trigger_pin),
    .rise(pin_rise)
  );

  assign cmd_wr = reg_wr && (reg_addr == REG_STATE_CONTROL);
  assign cmd = reg_wdata[CMD_LSB +: 5];
  assign start_evt = (state_q == S_RETRY_IDLE) && (pin_rise || (cmd_wr && cmd == CMD_TX_START));
  assign backoff_limit = ext_a_q[BCNT_LSB +: 3];
  assign frame_limit = ext_a_q[FCNT_LSB +: 4];
  // only a valid acknowledgment ends the wait before the timeout
  assign ack_ok = rx_end && rx_fcs_ok && rx_is_ack;

  // Configuration registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_mask_q <= IRQ_MASK_RST;
      ctrl_b_q <= CTRL_RST;
      ext_a_q <= EXT_A_RST;
      ext_b_q <= CTRL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_IRQ_MASK: irq_mask_q <= reg_wdata;
        REG_RADIO_CTRL_B: ctrl_b_q <= reg_wdata;
        REG_EXT_CTRL_A: ext_a_q <= reg_wdata;
        REG_EXT_CTRL_B: ext_b_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Main sequencer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= S_OFF;
      result_q <= RES_SUCCESS;
      bcnt_q <= 3'h0;
      fcnt_q <= 4'h0;
      tmr_q <= '0;
      amatch_q <= 1'b0;
      cca_start <= 1'b0;
      tx_start <= 1'b0;
      tx_is_ack <= 1'b0;
      irq_set <= 8'h00;
    end else begin
      cca_start <= 1'b0;
      tx_start <= 1'b0;
      irq_set <= 8'h00;
      if (tmr_q != '0) begin
        tmr_q <= tmr_q - 1'b1;
      end
      if (cmd_wr && cmd == CMD_OFF) begin
        state_q <= S_OFF;
      end else begin
        case (state_q)
          S_OFF, S_PLL: begin
            if (cmd_wr && cmd == CMD_PLL_ON) begin
              state_q <= S_PLL;
            end else if (cmd_wr && (cmd == CMD_AUTOACK_ON || cmd == CMD_RETRY_ON)) begin
              state_q <= (cmd == CMD_AUTOACK_ON) ? S_LISTEN : S_RETRY_IDLE;
              irq_set[IRQ_PLL_BIT] <= (state_q == S_OFF);
            end
          end
          S_LISTEN: begin
            if (rx_sfd) begin
              state_q <= S_BUSY_RX;
              result_q <= RES_INVALID;
              amatch_q <= 1'b0;
            end
          end
          S_BUSY_RX: begin
            irq_set[IRQ_RXSTART_BIT] <= rx_phr_ok;
            irq_set[IRQ_AMI_BIT] <= rx_addr_match;
            if (rx_addr_match) begin
              amatch_q <= 1'b1;
            end
            if (rx_end) begin
              state_q <= S_LISTEN;
              if (rx_fcs_ok && (amatch_q || rx_addr_match)) begin
                // completion only for filtered valid frames
                irq_set[IRQ_DONE_BIT] <= 1'b1;
                result_q <= RES_SUCCESS;
                if (rx_ack_req) begin
                  state_q <= S_ACK_DLY;
                  tmr_q <= ext_b_q[ACK_DELAY_BIT] ? TMR_W'(ACK_SHORT_CYCLES - 1) : TMR_W'(ACK_STD_CYCLES - 1);
                end
              end
            end
          end
          S_ACK_DLY: begin
            if (tmr_q == '0) begin
              tx_start <= 1'b1;
              tx_is_ack <= 1'b1;
              state_q <= S_ACK_TX;
            end
          end
          S_ACK_TX: begin
            if (tx_done) begin
              tx_is_ack <= 1'b0;
              state_q <= S_LISTEN;
            end
          end
          S_RETRY_IDLE: begin
            if (start_evt) begin
              result_q <= RES_INVALID;
              bcnt_q <= 3'h0;
              fcnt_q <= 4'h0;
              if (backoff_limit == BACKOFF_NO_CSMA) begin
                state_q <= S_TX;
                tx_start <= 1'b1;
              end else begin
                state_q <= S_CSMA;
                cca_start <= 1'b1;
              end
            end
          end
          S_CSMA: begin
            if (cca_done) begin
              if (cca_idle) begin
                state_q <= S_TX;
                tx_start <= 1'b1;
              end else if (bcnt_q == backoff_limit) begin
                result_q <= RES_CHAN_BUSY;
                irq_set[IRQ_DONE_BIT] <= 1'b1;
                state_q <= S_RETRY_IDLE;
              end else begin
                bcnt_q <= bcnt_q + 3'h1;
                cca_start <= 1'b1;
              end
            end
          end
          S_TX: begin
            if (tx_done) begin
              // acknowledge request from frame octet one
              if (fb_octet1_bit) begin
                state_q <= S_ACK_WAIT;
                tmr_q <= TMR_W'(ACK_TMO_CYCLES - 1);
              end else begin
                result_q <= RES_SUCCESS;
                irq_set[IRQ_DONE_BIT] <= 1'b1;
                state_q <= S_RETRY_IDLE;
              end
            end
          end
          S_ACK_WAIT: begin
            if (ack_ok) begin
              result_q <= rx_frame_pending ? RES_PENDING : RES_SUCCESS;
              irq_set[IRQ_DONE_BIT] <= 1'b1;
              state_q <= S_RETRY_IDLE;
            end else if (tmr_q == '0) begin
              if (backoff_limit == BACKOFF_NO_CSMA || fcnt_q == frame_limit) begin
                result_q <= RES_NO_ACK;
                irq_set[IRQ_DONE_BIT] <= 1'b1;
                state_q <= S_RETRY_IDLE;
              end else begin
                fcnt_q <= fcnt_q + 4'h1;
                bcnt_q <= 3'h0;
                state_q <= S_CSMA;
                cca_start <= 1'b1;
              end
            end
          end
          default: state_q <= S_OFF;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_stat_q <= 8'h00;
      irq_pin <= 1'b0;
    end else begin
      if (reg_rd && reg_addr == REG_IRQ_STATUS) begin
        irq_stat_q <= irq_set & irq_mask_q;
      end else begin
        irq_stat_q <= irq_stat_q | (irq_set & irq_mask_q);
      end
      irq_pin <= |(irq_stat_q & irq_mask_q);
    end
  end

  // timestamp strobe and buffer write guard
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timestamp_pin <= 1'b0;
      fb_rx_write_en <= 1'b0;
    end else begin
      timestamp_pin <= (state_q == S_TX) && ctrl_b_q[ROUTE_EN_BIT] && ext_b_q[TS_EN_BIT];
      fb_rx_write_en <= (state_q == S_LISTEN) || (state_q == S_BUSY_RX);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      REG_STATE_READBACK: rdata_d = {3'h0, state_code(state_q)};
      REG_STATE_CONTROL: rdata_d = {result_q, 5'h00};
      REG_RADIO_CTRL_B: rdata_d = ctrl_b_q;
      REG_IRQ_MASK: rdata_d = irq_mask_q;
      REG_IRQ_STATUS: rdata_d = irq_stat_q;
      REG_EXT_CTRL_B: rdata_d = ext_b_q;
      REG_EXT_CTRL_C: rdata_d = {fcnt_q, bcnt_q, 1'b0};
      REG_EXT_CTRL_A: rdata_d = ext_a_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
    end
  end

  // Checks
  a_sfd_to_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q == S_LISTEN && rx_sfd && !cmd_wr |=> state_q == S_BUSY_RX && result_q == RES_INVALID)
    else $error("sfd did not enter busy receive");
  a_ack_delay_std: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q == S_BUSY_RX && rx_end && rx_fcs_ok && amatch_q && rx_ack_req && !ext_b_q[ACK_DELAY_BIT] && !cmd_wr
    |=> tmr_q == TMR_W'(ACK_STD_CYCLES - 1))
    else $error("standard ack delay not loaded");
  a_csma_first: assert property (@(posedge core_clk) disable iff (sys_rst)
    start_evt && backoff_limit != BACKOFF_NO_CSMA && !(cmd_wr && cmd == CMD_OFF) |=> state_q == S_CSMA && cca_start)
    else $error("csma not started first");
  a_chan_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q == S_CSMA && cca_done && !cca_idle && bcnt_q == backoff_limit && !cmd_wr
    |=> result_q == RES_CHAN_BUSY && state_q == S_RETRY_IDLE && irq_set[IRQ_DONE_BIT])
    else $error("busy channel not reported");
  a_no_ack_done: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q == S_TX && tx_done && !fb_octet1_bit && !cmd_wr |=> result_q == RES_SUCCESS && state_q == S_RETRY_IDLE)
    else $error("no-ack transmit not completed");
  a_single_shot: assert property (@(posedge core_clk) disable iff (sys_rst)
    start_evt && backoff_limit == BACKOFF_NO_CSMA && !(cmd_wr && cmd == CMD_OFF) |=> state_q == S_TX && tx_start)
    else $error("limit seven did not skip csma");
  a_ack_pending: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q == S_ACK_WAIT && ack_ok && !cmd_wr |=> result_q[2:1] == 2'h0 && result_q[0] == $past(rx_frame_pending))
    else $error("ack result wrong");
  a_fbuf_guard: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q inside {S_RETRY_IDLE, S_CSMA, S_TX, S_ACK_WAIT} ##1 state_q != S_LISTEN |-> !fb_rx_write_en)
    else $error("buffer writable during retry mode");
  a_irq_masked: assert property (@(posedge core_clk) disable iff (sys_rst)
    !irq_mask_q[IRQ_DONE_BIT] && !$past(irq_stat_q[IRQ_DONE_BIT]) |-> !irq_stat_q[IRQ_DONE_BIT] || $past(irq_mask_q[IRQ_DONE_BIT]))
    else $error("masked interrupt raised");
endmodule : aret_engine

// ---- dv/aret_radio_model.sv ----
// Radio front-end model answering CCA, transmit and receive requests
module aret_radio_model (
  // Clock
  input logic core_clk,
  // Requests from the sequencer
  input logic cca_start,
  input logic tx_start,
  input logic tx_is_ack,
  // Answers
  output logic cca_done,
  output logic cca_idle,
  output logic tx_done,
  output logic rx_sfd,
  output logic rx_phr_ok,
  output logic rx_addr_match,
  output logic rx_end,
  output logic rx_fcs_ok,
  output logic rx_is_ack,
  output logic rx_ack_req,
  output logic rx_frame_pending
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bench knobs: busy answers left, reply kind (0 none, 1 ack, 2 ack pending)
  int busy_left = 0;
  int ack_mode = 0;
  bit junk = 0;
  int n_cca = 0;
  int n_tx = 0;
  logic was_ack;

  initial begin
    {cca_done, cca_idle, tx_done, rx_sfd, rx_phr_ok, rx_addr_match} = '0;
    {rx_end, rx_fcs_ok, rx_is_ack, rx_ack_req, rx_frame_pending} = '0;
  end

  // Levels are inverted once stale so nothing passes by luck
  task automatic frame(input logic ack, input logic pend, input logic areq);
    rx_sfd <= 1'b1;
    @(posedge core_clk);
    rx_sfd <= 1'b0;
    rx_phr_ok <= 1'b1;
    @(posedge core_clk);
    rx_phr_ok <= 1'b0;
    rx_addr_match <= ~ack;
    @(posedge core_clk);
    rx_addr_match <= 1'b0;
    repeat (3) @(posedge core_clk);
    {rx_end, rx_fcs_ok, rx_is_ack, rx_frame_pending, rx_ack_req} <= {2'b11, ack, pend, areq};
    @(posedge core_clk);
    {rx_end, rx_fcs_ok, rx_is_ack, rx_frame_pending, rx_ack_req} <= {2'b00, ~ack, ~pend, ~areq};
  endtask : frame

  always @(posedge core_clk) begin
    if (cca_start) begin
      n_cca++;
      repeat (3) @(posedge core_clk);
      cca_done <= 1'b1;
      cca_idle <= (busy_left == 0);
      if (busy_left > 0)
        busy_left--;
      @(posedge core_clk);
      cca_done <= 1'b0;
      cca_idle <= ~cca_idle;
    end
  end

  always @(posedge core_clk) begin
    if (tx_start) begin
      n_tx++;
      was_ack = tx_is_ack;
      repeat (5) @(posedge core_clk);
      tx_done <= 1'b1;
      @(posedge core_clk);
      tx_done <= 1'b0;
      if (!was_ack && ack_mode != 0) begin
        repeat (4) @(posedge core_clk);
        if (junk)
          frame(1'b0, 1'b1, 1'b1);
        frame(1'b1, ack_mode == 2, 1'b0);
      end
    end
  end
endmodule : aret_radio_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the retry-transmit and auto-acknowledge sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import aret_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pin = 1'b0;
  logic fb_bit = 1'b0;
  logic irq_pin, timestamp_pin, cca_start, cca_done, cca_idle, tx_start, tx_is_ack, tx_done;
  logic rx_sfd, rx_phr_ok, rx_addr_match, rx_end, rx_fcs_ok, rx_is_ack, rx_ack_req, rx_frame_pending;
  logic fb_rx_write_en;
  int n_errors = 0;
  int total_checks = 0;
  bit ts_seen, wen_seen;
  int c0, t0;
  int d[2];

  aret_engine #(.ACK_STD_CYCLES(12), .ACK_SHORT_CYCLES(2), .ACK_TMO_CYCLES(54)) u_aret_engine (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_tx_trigger_pin(pin),
    .irq_pin(irq_pin), .timestamp_pin(timestamp_pin), .cca_start(cca_start), .cca_done(cca_done),
    .cca_idle(cca_idle), .tx_start(tx_start), .tx_is_ack(tx_is_ack), .tx_done(tx_done),
    .fb_octet1_bit(fb_bit), .rx_sfd(rx_sfd), .rx_phr_ok(rx_phr_ok), .rx_addr_match(rx_addr_match),
    .rx_end(rx_end), .rx_fcs_ok(rx_fcs_ok), .rx_is_ack(rx_is_ack), .rx_ack_req(rx_ack_req),
    .rx_frame_pending(rx_frame_pending), .fb_rx_write_en(fb_rx_write_en));

  aret_radio_model u_aret_radio_model (
    .core_clk(core_clk), .cca_start(cca_start), .tx_start(tx_start), .tx_is_ack(tx_is_ack),
    .cca_done(cca_done), .cca_idle(cca_idle), .tx_done(tx_done), .rx_sfd(rx_sfd),
    .rx_phr_ok(rx_phr_ok), .rx_addr_match(rx_addr_match), .rx_end(rx_end), .rx_fcs_ok(rx_fcs_ok),
    .rx_is_ack(rx_is_ack), .rx_ack_req(rx_ack_req), .rx_frame_pending(rx_frame_pending));

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  // Sticky flags for pins that only matter while transmitting, listening or receiving
  always @(posedge core_clk) begin
    if (timestamp_pin === 1'b1) ts_seen = 1;
    if (fb_rx_write_en === 1'b1) wen_seen = 1;
  end

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask : rd

  // Bounded wait; a hang ends the run
  task automatic wait_irq(input int lim);
    int i;
    i = 0;
    while (irq_pin !== 1'b1 && i < lim) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    if (irq_pin !== 1'b1) begin
      n_errors++;
      $display("MISMATCH at %0t: interrupt never came", $time);
      conclude();
    end
  endtask : wait_irq

  task automatic t_reset();
    wr(REG_STATE_READBACK, 8'hff);
    wr(6'h3f, 8'hff);
    rd(REG_STATE_READBACK, {3'h0, ST_OFF}, "readback"); // off state
    rd(REG_STATE_CONTROL, 8'h00, "result"); // resets zero
    rd(REG_IRQ_MASK, IRQ_MASK_RST, "mask"); // mask clear
    rd(REG_EXT_CTRL_A, EXT_A_RST, "limits"); // limit field
    rd(6'h3f, 8'h00, "unmapped");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_enter();
    wr(REG_IRQ_MASK, 8'h09);
    wr(REG_STATE_CONTROL, {3'h0, CMD_RETRY_ON});
    rd(REG_STATE_READBACK, {3'h0, ST_RETRY_IDLE}, "retry idle"); // idle state
    wait_irq(20);
    rd(REG_IRQ_STATUS, 8'h01, "lock irq"); // lock raised
    rd(REG_IRQ_STATUS, 8'h00, "read clear"); // status cleared
    $display("t_enter done");
  endtask : t_enter

  task automatic t_noack_req();
    c0 = u_aret_radio_model.n_cca;
    t0 = u_aret_radio_model.n_tx;
    ts_seen = 0;
    wr(REG_STATE_CONTROL, {3'h0, CMD_TX_START});
    rd(REG_STATE_CONTROL, {RES_INVALID, 5'h00}, "in progress"); // invalid loaded
    rd(REG_STATE_READBACK, {3'h0, ST_BUSY_RT}, "busy"); // busy state
    wait_irq(200);
    rd(REG_STATE_CONTROL, {RES_SUCCESS, 5'h00}, "success"); // success code
    rd(REG_STATE_READBACK, {3'h0, ST_RETRY_IDLE}, "back idle"); // back idle
    rd(REG_IRQ_STATUS, 8'h08, "done irq"); // completion irq
    chk(8'(u_aret_radio_model.n_cca - c0), 8'h01, "cca count"); // one assessment
    chk(8'(u_aret_radio_model.n_tx - t0), 8'h01, "tx count"); // single send
    chk(8'(ts_seen), 8'h00, "no stamp"); // enables off
    $display("t_noack_req done");
  endtask : t_noack_req

  task automatic t_ack_pending();
    wr(REG_IRQ_MASK, 8'h28);
    wr(REG_STATE_CONTROL, {3'h0, CMD_OFF});
    wr(REG_RADIO_CTRL_B, 8'h40);
    wr(REG_EXT_CTRL_B, 8'h08);
    wr(REG_STATE_CONTROL, {3'h0, CMD_RETRY_ON});
    u_aret_radio_model.ack_mode = 2;
    u_aret_radio_model.junk = 1;
    ts_seen = 0;
    @(posedge core_clk);
    fb_bit <= 1'b1;
    pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    pin <= 1'b0;
    wait_irq(300);
    rd(REG_STATE_CONTROL, {RES_PENDING, 5'h00}, "pending"); // pending code
    rd(REG_IRQ_STATUS, 8'h08, "no match irq"); // ack silent
    chk(8'(ts_seen), 8'h01, "stamp"); // stamp shown
    u_aret_radio_model.ack_mode = 0;
    u_aret_radio_model.junk = 0;
    $display("t_ack_pending done");
  endtask : t_ack_pending

  task automatic t_busy();
    c0 = u_aret_radio_model.n_cca;
    t0 = u_aret_radio_model.n_tx;
    u_aret_radio_model.busy_left = 100;
    wr(REG_STATE_CONTROL, {3'h0, CMD_TX_START});
    wait_irq(300);
    rd(REG_STATE_CONTROL, {RES_CHAN_BUSY, 5'h00}, "busy code"); // busy code
    rd(REG_EXT_CTRL_C, 8'h08, "backoff count"); // count readable
    rd(REG_IRQ_STATUS, 8'h08, "done irq"); // completion irq
    chk(8'(u_aret_radio_model.n_cca - c0), 8'h05, "cca tries"); // limit plus one
    chk(8'(u_aret_radio_model.n_tx - t0), 8'h00, "no tx"); // busy no send
    u_aret_radio_model.busy_left = 0;
    $display("t_busy done");
  endtask : t_busy

  task automatic t_no_ack();
    c0 = u_aret_radio_model.n_cca;
    t0 = u_aret_radio_model.n_tx;
    wr(REG_STATE_CONTROL, {3'h0, CMD_TX_START});
    rd(REG_EXT_CTRL_C, 8'h00, "counts cleared"); // fresh counts
    wait_irq(2000);
    rd(REG_STATE_CONTROL, {RES_NO_ACK, 5'h00}, "no ack"); // no-ack code
    rd(REG_EXT_CTRL_C, 8'h30, "frame count"); // frame count
    rd(REG_IRQ_STATUS, 8'h08, "done irq"); // completion irq
    chk(8'(u_aret_radio_model.n_tx - t0), 8'h04, "attempts"); // limit plus one
    chk(8'(u_aret_radio_model.n_cca - c0), 8'h04, "cca per try"); // whole retry
    chk(8'(wen_seen), 8'h00, "buffer kept"); // buffer untouched
    $display("t_no_ack done");
  endtask : t_no_ack

  task automatic t_once();
    c0 = u_aret_radio_model.n_cca;
    t0 = u_aret_radio_model.n_tx;
    wr(REG_STATE_CONTROL, {3'h0, CMD_OFF});
    wr(REG_RADIO_CTRL_B, 8'h00);
    wr(REG_EXT_CTRL_B, 8'h00);
    wr(REG_EXT_CTRL_A, 8'h3e);
    wr(REG_STATE_CONTROL, {3'h0, CMD_RETRY_ON});
    wr(REG_STATE_CONTROL, {3'h0, CMD_TX_START});
    wait_irq(300);
    rd(REG_STATE_CONTROL, {RES_NO_ACK, 5'h00}, "single no ack"); // one attempt
    rd(REG_IRQ_STATUS, 8'h08, "done irq"); // completion irq
    chk(8'(u_aret_radio_model.n_cca - c0), 8'h00, "no cca"); // skip assessment
    chk(8'(u_aret_radio_model.n_tx - t0), 8'h01, "one tx"); // single send
    $display("t_once done");
  endtask : t_once

  task automatic t_autoack();
    wr(REG_STATE_CONTROL, {3'h0, CMD_OFF});
    wr(REG_IRQ_MASK, 8'h2c);
    wr(REG_STATE_CONTROL, {3'h0, CMD_AUTOACK_ON});
    for (int s = 0; s < 2; s++) begin
      wr(REG_EXT_CTRL_B, 8'(s << ACK_DELAY_BIT));
      fork
        u_aret_radio_model.frame(1'b0, 1'b0, 1'b1);
        rd(REG_STATE_READBACK, {3'h0, ST_BUSY_AA}, "busy rx"); // busy on delimiter
      join
      #1;
      d[s] = 0;
      while (tx_start !== 1'b1 && d[s] < 200) begin
        @(posedge core_clk);
        #1;
        d[s]++;
      end
      if (tx_start !== 1'b1) begin
        chk(tx_start, 1'b1, "ack start"); // timeout
        conclude();
      end
      chk(tx_is_ack, 1'b1, "ack frame"); // auto ack
      repeat (12) @(posedge core_clk);
      rd(REG_STATE_READBACK, {3'h0, ST_LISTEN}, "listen"); // back listening
      rd(REG_IRQ_STATUS, 8'h2c, "rx irqs"); // header match done
      rd(REG_STATE_CONTROL, {RES_SUCCESS, 5'h00}, "rx result"); // success
    end
    chk(8'(d[0] - d[1]), 8'(12 - 2), "ack delay gap"); // short delay
    chk(8'(wen_seen), 8'h01, "rx buffer open"); // listen and busy receive
    $display("t_autoack done");
  endtask : t_autoack

  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_enter();
    t_noack_req();
    t_ack_pending();
    t_busy();
    @(posedge core_clk);
    fb_bit <= 1'b1;
    t_no_ack();
    t_once();
    t_autoack();
    conclude();
  end
endmodule : tb_top
